// [rtl/lbs_pkg.sv]
package lbs_pkg;

	localparam logic [7:0]  ATTR_D8_DF_OFS  = 8'h94;
	localparam logic [7:0]  ATTR_E0_E7_OFS  = 8'h95;
	localparam logic [7:0]  ATTR_E8_EF_OFS  = 8'h96;
	localparam logic [7:0]  ATTR_RESET      = 8'h00;
	localparam logic [7:0]  ATTR_WR_MASK    = 8'h33;
	localparam int          LOWER_LSB       = 0;
	localparam int          UPPER_LSB       = 4;
	localparam int          NUM_SEGMENTS    = 6;
	localparam logic [19:0] WINDOW_BASE     = 20'hD_8000;
	localparam logic [19:0] WINDOW_END      = 20'hE_FFFF;
	localparam int          SEG_SHIFT       = 14;
	localparam logic [1:0]  ATTR_HUB_ONLY   = 2'h0;
	localparam logic [1:0]  ATTR_READ_DRAM  = 2'h1;
	localparam logic [1:0]  ATTR_WRITE_DRAM = 2'h2;
	localparam logic [1:0]  ATTR_ALL_DRAM   = 2'h3;

	typedef enum logic [0:0]
	{
		LBS_TGT_HUB,
		LBS_TGT_DRAM
	} lbs_target_e;

	// Configuration access, bus 0 device 0 function 0, after the host decode
	typedef struct packed
	{
		logic       rd;
		logic       wr;
		logic [7:0] ofs;
		logic [3:0] be;
		logic [31:0] wdata;
	} lbs_cfg_req_s;

	typedef struct packed
	{
		logic        valid;
		logic        write;
		logic [31:0] addr;
	} lbs_mem_req_s;

	typedef struct packed
	{
		logic        hit;
		logic        to_dram;
		logic        to_hub;
	} lbs_route_s;

endpackage : lbs_pkg

// [rtl/lbs_seg_steer.sv]
module lbs_seg_steer
	import lbs_pkg::*;
(
	input  wire logic [1:0] attr_i,
	input  wire logic       write_i,
	output lbs_target_e     target_o
);

	always_comb
	begin
		case (attr_i)
			ATTR_HUB_ONLY:   target_o = LBS_TGT_HUB;
			ATTR_READ_DRAM:  target_o = write_i ? LBS_TGT_HUB : LBS_TGT_DRAM;
			ATTR_WRITE_DRAM: target_o = write_i ? LBS_TGT_DRAM : LBS_TGT_HUB;
			ATTR_ALL_DRAM:   target_o = LBS_TGT_DRAM;
			default:         target_o = LBS_TGT_HUB;
		endcase
	end

endmodule : lbs_seg_steer

// [rtl/lbs_shadow_steer.sv]
// What this block does
// - 8-bit attribute register at offset 94h covers 0D8000h-0DFFFFh.
// - Offset 94h bits 5:4 steer 0DC000h-0DFFFFh.
// - Offset 94h bits 1:0 steer 0D8000h-0DBFFFh.
// - Offset 95h covers 0E0000h-0E7FFFh; low and high fields per segment.
// - Offset 96h covers 0E8000h-0EFFFFh; low and high fields per segment.
// - Field 00 sends all reads and writes to the hub link.
// - Field 01 reads from DRAM, writes to the hub link.
// - Field 10 writes to DRAM, reads from the hub link.
// - Field 11 sends reads and writes to DRAM.
// - Registers sit in configuration space of bus 0, device 0, function 0.
module lbs_shadow_steer
	import lbs_pkg::*;
(
	input  wire logic                  clk_i,
	input  wire logic                  sys_rst_i,
	input  wire lbs_pkg::lbs_cfg_req_s cfg_req_i,
	output logic [31:0]                cfg_rdata_o,
	output logic                       cfg_rvalid_o,
	input  wire lbs_pkg::lbs_mem_req_s mem_req_i,
	output lbs_pkg::lbs_route_s        route_o
);

	import lbs_pkg::*;

	logic [7:0]  attr_d8_df_q;
	logic [7:0]  attr_e0_e7_q;
	logic [7:0]  attr_e8_ef_q;
	logic        cfg_dword_hit;
	logic        wr_d8_df;
	logic        wr_e0_e7;
	logic        wr_e8_ef;
	logic [31:0] rdata_d;
	logic [7:0]  dword_base;
	logic        in_window;
	logic [2:0]  seg_idx;
	logic [1:0]  seg_field  [NUM_SEGMENTS];
	lbs_target_e seg_target [NUM_SEGMENTS];
	lbs_target_e target;

	// Config dwords are addressed by the upper offset bits; 94h..96h share dword 94h
	assign dword_base = {cfg_req_i.ofs[7:2], 2'b00};

	assign cfg_dword_hit = dword_base == {ATTR_D8_DF_OFS[7:2], 2'b00};

	// Byte lane of each register is its offset's low bits; lane 3 belongs to another block
	assign wr_d8_df = cfg_req_i.wr && cfg_dword_hit && cfg_req_i.be[ATTR_D8_DF_OFS[1:0]];
	assign wr_e0_e7 = cfg_req_i.wr && cfg_dword_hit && cfg_req_i.be[ATTR_E0_E7_OFS[1:0]];
	assign wr_e8_ef = cfg_req_i.wr && cfg_dword_hit && cfg_req_i.be[ATTR_E8_EF_OFS[1:0]];

	// Reserved bits are masked on the way in, so they can never read back as one
	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			attr_d8_df_q <= ATTR_RESET;
		else if (wr_d8_df)
			attr_d8_df_q <= cfg_req_i.wdata[8 * ATTR_D8_DF_OFS[1:0] +: 8] & ATTR_WR_MASK;
	end

	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			attr_e0_e7_q <= ATTR_RESET;
		else if (wr_e0_e7)
			attr_e0_e7_q <= cfg_req_i.wdata[8 * ATTR_E0_E7_OFS[1:0] +: 8] & ATTR_WR_MASK;
	end

	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			attr_e8_ef_q <= ATTR_RESET;
		else if (wr_e8_ef)
			attr_e8_ef_q <= cfg_req_i.wdata[8 * ATTR_E8_EF_OFS[1:0] +: 8] & ATTR_WR_MASK;
	end

	// Other dwords read as zero, and so does lane 3 of ours
	always_comb
	begin
		rdata_d = 32'h0000_0000;
		if (cfg_dword_hit)
		begin
			rdata_d[8 * ATTR_D8_DF_OFS[1:0] +: 8] = attr_d8_df_q;
			rdata_d[8 * ATTR_E0_E7_OFS[1:0] +: 8] = attr_e0_e7_q;
			rdata_d[8 * ATTR_E8_EF_OFS[1:0] +: 8] = attr_e8_ef_q;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			cfg_rvalid_o <= 1'b0;
		else
			cfg_rvalid_o <= cfg_req_i.rd;
	end

	// Read data holds until the next read so a slow host can still pick it up
	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			cfg_rdata_o <= 32'h0000_0000;
		else if (cfg_req_i.rd)
			cfg_rdata_o <= rdata_d;
	end

	// Segment order: D8, DC, E0, E4, E8, EC
	assign seg_field[0] = attr_d8_df_q[LOWER_LSB +: 2];
	assign seg_field[1] = attr_d8_df_q[UPPER_LSB +: 2];
	assign seg_field[2] = attr_e0_e7_q[LOWER_LSB +: 2];
	assign seg_field[3] = attr_e0_e7_q[UPPER_LSB +: 2];
	assign seg_field[4] = attr_e8_ef_q[LOWER_LSB +: 2];
	assign seg_field[5] = attr_e8_ef_q[UPPER_LSB +: 2];

	assign in_window = mem_req_i.addr[31:20] == 12'h000
		&& mem_req_i.addr[19:0] >= WINDOW_BASE
		&& mem_req_i.addr[19:0] <= WINDOW_END;

	// 16 KB segments; D8000h is segment 0
	always_comb
	begin
		logic [19:0] off;
		off     = mem_req_i.addr[19:0] - WINDOW_BASE;
		seg_idx = off[SEG_SHIFT +: 3];
	end

	// One decoder per segment keeps the select off the attribute path
	for (genvar g = 0; g < NUM_SEGMENTS; g++)
	begin : g_seg
		lbs_seg_steer u_lbs_seg_steer
		(
			.attr_i   (seg_field[g]),
			.write_i  (mem_req_i.write),
			.target_o (seg_target[g])
		);
	end

	// Index is guarded so an address outside the window never reads past the array
	always_comb
	begin
		target = LBS_TGT_HUB;
		if (in_window && seg_idx < 3'(NUM_SEGMENTS))
			target = seg_target[seg_idx];
	end

	// Outside the window the route is left to other decoders; hit stays low
	always_comb
	begin
		route_o.hit     = mem_req_i.valid && in_window;
		route_o.to_dram = route_o.hit && target == LBS_TGT_DRAM;
		route_o.to_hub  = route_o.hit && target == LBS_TGT_HUB;
	end

endmodule : lbs_shadow_steer

// [verification/lbs_shadow_steer_properties.sv]
module lbs_shadow_steer_chk
	import lbs_pkg::*;
(
	input wire logic         clk_i,
	input wire logic         sys_rst_i,
	input wire lbs_cfg_req_s cfg_req_i,
	input wire logic         cfg_rvalid_o,
	input wire logic [31:0]  cfg_rdata_o,
	input wire lbs_mem_req_s mem_req_i,
	input wire lbs_route_s   route_o
);
	timeunit 1ns / 1ns;
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	property p_rv; cfg_rvalid_o == $past(cfg_req_i.rd); endproperty
	a_rv: assert property (p_rv) else $error("read answer out of step");
	property p_one; route_o.hit |-> route_o.to_dram != route_o.to_hub; endproperty
	a_one: assert property (p_one) else $error("route claims two targets");
	property p_miss; !route_o.hit |-> !route_o.to_dram && !route_o.to_hub; endproperty
	a_miss: assert property (p_miss) else $error("route without a hit");
	property p_win;
		route_o.hit == (mem_req_i.valid && mem_req_i.addr >= 32'h000D_8000
			&& mem_req_i.addr <= 32'h000E_FFFF);
	endproperty
	a_win: assert property (p_win) else $error("hit disagrees with window");
	property p_rsv; cfg_rvalid_o |-> (cfg_rdata_o & 32'hFFCC_CCCC) == 32'h0000_0000; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved read bits set");
	property p_hold; !cfg_req_i.rd |=> $stable(cfg_rdata_o); endproperty
	a_hold: assert property (p_hold) else $error("read data moved without a read");
endmodule : lbs_shadow_steer_chk
bind lbs_shadow_steer lbs_shadow_steer_chk u_chk (.clk_i, .sys_rst_i, .cfg_req_i, .cfg_rvalid_o,
	.cfg_rdata_o, .mem_req_i, .route_o);

// [verification/lbs_far_end.sv]
module lbs_far_end
	import lbs_pkg::*;
(
	input  wire lbs_route_s route_i,
	output logic [1:0]      took_o
);
	timeunit 1ns / 1ns;
	// Both bits set means DRAM and hub link would both answer
	assign took_o = {route_i.to_dram, route_i.to_hub};
endmodule : lbs_far_end

// [verification/tb_lbs_shadow_steer.sv]
module tb_lbs_shadow_steer;
	import lbs_pkg::*;
	timeunit 1ns / 1ns;
	logic clk_i = 0, sys_rst_i = 1, rv;
	logic [31:0] rd;
	logic [7:0] mr [3] = '{0, 0, 0};
	logic [1:0] tk;
	lbs_cfg_req_s q = '0;
	lbs_mem_req_s m = '0;
	lbs_route_s r;
	int failures = 0, n_compared = 0, f;
	always #50 clk_i = ~clk_i;
	lbs_shadow_steer u_lbs_shadow_steer (.clk_i, .sys_rst_i, .cfg_req_i(q), .cfg_rdata_o(rd),
		.cfg_rvalid_o(rv), .mem_req_i(m), .route_o(r));
	lbs_far_end u_lbs_far_end (.route_i(r), .took_o(tk));
	task cmp_rd(input logic [32:0] g, logic [32:0] e);
		n_compared++;
		if (g !== e)
		begin
			failures++;
			$display("[ERR] %0t %h %h", $time, g, e);
		end
	endtask : cmp_rd
	task cmp_rt(input logic [4:0] g, logic [4:0] e);
		n_compared++;
		if (g !== e)
		begin
			failures++;
			$display("[ERR] %0t %h %h", $time, g, e);
		end
	endtask : cmp_rt
	task cfg(input logic w, logic [7:0] o, logic [3:0] b, logic [31:0] d);
		@(posedge clk_i);
		q <= '{!w, w, o, b, d};
		@(posedge clk_i);
		q <= '0;
		for (int i = 0; i < 3; i++)
			if (w && o == 8'h94 && b[i])
				mr[i] = d[8 * i +: 8] & 8'h33;
		#1 if (!w)
			cmp_rd({rv, rd}, {1'b1, o == 8'h94 ? {8'h0, mr[2], mr[1], mr[0]} : 32'h0});
	endtask : cfg
	task ck(input logic [31:0] a, logic w, logic v = 1);
		@(posedge clk_i);
		m <= '{v, w, a};
		f = a inside {[32'hD_8000:32'hE_FFFF]} ? mr[(a - 32'hD_8000) >> 15] >> a[14] * 4 & 3 : 4;
		#1 cmp_rt({r, tk}, !v || f > 3 ? 5'h00 : f >> w & 1 ? 5'h1A : 5'h15);
	endtask : ck
	task stop_test;
		$display("%0d compared, %0d failed", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : stop_test
	initial
	begin
		f = $urandom(32'h1186_34bd);
		repeat (2) @(posedge clk_i);
		sys_rst_i <= 0;
		for (int i = 0; i < 16; i++)
		begin
			cfg(0, i[0] ? 8'h98 : 8'h94, 0, 0);
			cfg(1, i[1] ? 8'h98 : 8'h94, 4'($urandom), $urandom);
			for (int k = 0; k < 12; k++)
				ck(32'hD_8000 + k * 32'h2000 + $urandom % 32'h2000, $urandom);
			ck(i[0] ? 32'hD_7FFF : 32'hF_0000, i[2]);
			ck(32'h010D_8000 + $urandom % 32'h1_8000, i[3]);
			ck(32'hD_8000 + $urandom % 32'h1_8000, i[2], 0);
		end
		@(posedge clk_i);
		sys_rst_i <= 1;
		@(posedge clk_i);
		sys_rst_i <= 0;
		mr = '{0, 0, 0};
		cfg(0, 8'h94, 0, 0);
		ck(32'hE_C000, 0);
		stop_test();
	end
endmodule : tb_lbs_shadow_steer
